// ### design/adc_cal_pkg.sv
// Purpose: Shared constants and types for the converter control link
// Assumes: Both link ends and the software bus use these names
// Notes: Maker id value is arbitrary
package adc_cal_pkg;
   // Core clock and serial timing
   localparam int CORE_PERIOD_NS = 100;
   localparam int SCLK_HALF_NS = 1000;
   localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam logic [4:0] CMD_BITS = 5'h08;

   // Register select codes
   typedef enum logic [2:0] {
      REG_COMM = 3'h0, REG_SETUP = 3'h1, REG_CLOCK = 3'h2, REG_RESULT = 3'h3,
      REG_TEST = 3'h4, REG_NOP = 3'h5, REG_OFFSET = 3'h6, REG_GAIN = 3'h7
   } reg_sel_t;

   // Operating modes
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0, MODE_SELF = 2'h1, MODE_ZERO = 2'h2, MODE_FULL = 2'h3
   } op_mode_t;

   // Command byte fields
   localparam int CMD_START = 7;
   localparam int CMD_RS_MSB = 6;
   localparam int CMD_RS_LSB = 4;
   localparam int CMD_RW = 3;
   localparam int CMD_PD = 2;
   localparam int CMD_CH_MSB = 1;

   // Setup register fields
   localparam int SET_MODE_MSB = 7;
   localparam int SET_MODE_LSB = 6;
   localparam int SET_GAIN_MSB = 5;
   localparam int SET_GAIN_LSB = 3;
   localparam int SET_UNIPOLAR = 2;
   localparam int SET_BUF = 1;
   localparam int SET_HOLD = 0;
   localparam logic [7:0] SETUP_RESET = 8'h01;

   // Clock register fields
   localparam int CLK_INTOSC = 5;
   localparam int CLK_OUTDIS = 4;
   localparam int CLK_HALVE = 3;
   localparam int CLK_FRANGE = 2;
   localparam int CLK_FS_MSB = 1;
   localparam logic [5:0] CLOCK_RESET_LOW = 6'h05;
   localparam logic MAKER_ID_VALUE = 1'b0; // Arbitrary value

   // Coefficient and result values
   localparam logic [23:0] OFFSET_RESET = 24'h1F4000;
   localparam logic [23:0] GAIN_RESET = 24'h5761AB;
   localparam logic [15:0] ZERO_UNIPOLAR = 16'h0000;
   localparam logic [15:0] ZERO_BIPOLAR = 16'h1000;
   localparam logic [7:0] TEST_RESET = 8'h00;

   // Modulator ticks per result, indexed by {frange, fs}
   localparam logic [8:0] DECIM [0:7] = '{9'd391, 9'd313, 9'd78, 9'd39,
                                          9'd384, 9'd320, 9'd77, 9'd38};

   // Link pin synchroniser idle levels {clock_input_pin, sdi, cs_n, sclk}
   localparam logic [3:0] PIN_IDLE = 4'h3;

   // Software register offsets of the host end
   localparam logic [3:0] HOST_TXDATA = 4'h0;
   localparam logic [3:0] HOST_COMMAND = 4'h4;
   localparam logic [3:0] HOST_STATUS = 4'h8;
   localparam logic [3:0] HOST_RXDATA = 4'hC;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Data bits following a command byte
   function automatic logic [4:0] data_bits(input logic [2:0] rs);
      case (rs)
         REG_RESULT: data_bits = 5'd16;
         REG_OFFSET, REG_GAIN: data_bits = 5'd24;
         REG_NOP: data_bits = 5'd0;
         default: data_bits = 5'd8;
      endcase
   endfunction : data_bits
endpackage : adc_cal_pkg

// ### design/adc_link_if.sv
// Purpose: Serial link between host end and converter end
// Assumes: Host drives clock, select and data in
// Notes: All lines are one-way
`timescale 1ns/100ps
interface adc_link_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   logic result_ready_n;

   modport device_end (input sclk, input cs_n, input sdi, output sdo, output result_ready_n);
   modport host_end (output sclk, output cs_n, output sdi, input sdo, input result_ready_n);
endinterface : adc_link_if

// ### design/adc_device_end.sv
// Purpose: Converter end: command decode, registers, calibration sequencer
// Assumes: Link pins are asynchronous to core_clk
// Notes: Modulator is stood in for by analog_sample
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - decode mode field, calibrate selected channel
// - self-cal runs zero then full, loads both
// - short inputs, then reference over gain
// - calibration end clears mode to normal
// - ready high on request, low on result
// - zero system cal updates offset only
// - full system cal updates gain only
// - gain code n gives two to n
// - top clock bit is fixed maker id
// - next clock bit reads zero always
// - internal oscillator follows its enable bit
// - clock output disable holds pin low
// - halve bit divides external clock only
// - range bit picks fast or slow oscillator
// - host sets range bit for external clock
// - filter bits and range set result rate
// - sixteen-bit read-only result shifted out
// - output changes falling, host samples rising
// - unipolar straight binary, bipolar offset binary
// - host never alters test register
// - offset and gain, 24 bits, per channel
// - short coefficient write is discarded
// - command byte precedes every register access
// - hold bit keeps filter and calibration reset
module adc_device_end import adc_cal_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Link
   adc_link_if.device_end link,
   // Analog stand-in and clock pins
   input wire logic [15:0] analog_sample,
   input wire logic clock_input_pin,
   input wire logic crystal_attached,
   // Analog and clock controls
   output logic input_short,
   output logic input_ref_level,
   output logic [7:0] amp_gain,
   output logic internal_osc_on,
   output logic osc_fast,
   output logic clock_output_pin,
   output logic power_down,
   output logic buffer_on
);
   typedef enum logic [1:0] {PH_CMD = 2'b01, PH_DATA = 2'b10} phase_t;
   typedef enum logic [3:0] {
      SQ_HOLD = 4'b0001, SQ_CONV = 4'b0010, SQ_ZERO = 4'b0100, SQ_FULL = 4'b1000
   } seq_t;

   logic [3:0] s1_q, s2_q, s3_q, pin_q, prev_q;
   phase_t phase_q;
   seq_t seq_q;
   logic [7:0] cmd_q, setup_q, test_q;
   logic [5:0] clock_q;
   logic [4:0] cnt_q;
   logic [23:0] rx_q, tx_q;
   logic [23:0] offset_q [0:2];
   logic [23:0] gain_q [0:2];
   logic [15:0] result_q;
   logic [8:0] period_q;
   logic sdo_q, ready_n_q, half_q;
   logic input_short_q, input_ref_q, osc_on_q, osc_fast_q, clock_output_pin_q, pd_q, buf_q;
   logic [7:0] amp_gain_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   wire [3:0] pin_raw = {clock_input_pin, link.sdi, link.cs_n, link.sclk};
   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge resetn) begin
         if (!resetn) begin
            s1_q[i] <= PIN_IDLE[i];
            s2_q[i] <= PIN_IDLE[i];
            s3_q[i] <= PIN_IDLE[i];
            pin_q[i] <= PIN_IDLE[i];
            prev_q[i] <= PIN_IDLE[i];
         end else begin
            s1_q[i] <= pin_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) pin_q[i] <= s3_q[i];
            prev_q[i] <= pin_q[i];
         end
      end
   end
   wire sclk_rise = pin_q[0] & ~prev_q[0];
   wire sclk_fall = ~pin_q[0] & prev_q[0];
   wire frame_off = pin_q[1];
   wire sdi_bit = pin_q[2];
   wire clock_input_pin_rise = pin_q[3] & ~prev_q[3];

   ////////////////////////////////////////////////////////////////////////////
   // Command and data decode
   wire [7:0] cmd_new = {rx_q[6:0], sdi_bit};
   wire [23:0] word_new = {rx_q[22:0], sdi_bit};
   wire [2:0] rs_new = cmd_new[CMD_RS_MSB:CMD_RS_LSB];
   wire [2:0] rs_cur = cmd_q[CMD_RS_MSB:CMD_RS_LSB];
   wire [4:0] len_new = data_bits(rs_new);
   wire [4:0] len_cur = data_bits(rs_cur);
   wire [1:0] ch = cmd_q[CMD_CH_MSB:0];
   wire [1:0] pair = (ch == 2'b01) ? 2'd1 : (ch == 2'b11) ? 2'd2 : 2'd0;
   wire [1:0] ch_new = cmd_new[CMD_CH_MSB:0];
   wire [1:0] pair_new = (ch_new == 2'b01) ? 2'd1 : (ch_new == 2'b11) ? 2'd2 : 2'd0;
   wire cmd_start = phase_q == PH_CMD && sclk_rise && !frame_off
                    && !(cnt_q == 5'd0 && sdi_bit);
   wire cmd_done = cmd_start && cnt_q == CMD_BITS - 5'd1;
   wire data_last = phase_q == PH_DATA && sclk_rise && !frame_off && cnt_q == len_cur - 5'd1;
   wire wr_go = data_last && !cmd_q[CMD_RW];
   wire rd_result_done = data_last && cmd_q[CMD_RW] && rs_cur == REG_RESULT;
   wire [7:0] clock_rd = {MAKER_ID_VALUE, 1'b0, clock_q};
   wire [7:0] comm_rd = {ready_n_q, cmd_new[6:0]};
   wire [23:0] rd_word =
      (rs_new == REG_COMM) ? {comm_rd, 16'h0000} :
      (rs_new == REG_SETUP) ? {setup_q, 16'h0000} :
      (rs_new == REG_CLOCK) ? {clock_rd, 16'h0000} :
      (rs_new == REG_RESULT) ? {result_q, 8'h00} :
      (rs_new == REG_TEST) ? {test_q, 16'h0000} :
      (rs_new == REG_OFFSET) ? offset_q[pair_new] :
      (rs_new == REG_GAIN) ? gain_q[pair_new] : 24'h000000;

   // Serial engine
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= PH_CMD;
         cnt_q <= 5'd0;
         cmd_q <= 8'h00;
         rx_q <= 24'h000000;
         tx_q <= 24'h000000;
         sdo_q <= 1'b0;
      end else if (frame_off) begin
         phase_q <= PH_CMD;
         cnt_q <= 5'd0;
      end else if (cmd_done) begin
         cmd_q <= cmd_new;
         cnt_q <= 5'd0;
         tx_q <= rd_word;
         if (len_new != 5'd0) phase_q <= PH_DATA;
      end else if (cmd_start || (phase_q == PH_DATA && sclk_rise)) begin
         rx_q <= word_new;
         cnt_q <= data_last ? 5'd0 : cnt_q + 5'd1;
         if (data_last) phase_q <= PH_CMD;
      end else if (sclk_fall && phase_q == PH_DATA && cmd_q[CMD_RW]) begin
         sdo_q <= tx_q[23];
         tx_q <= {tx_q[22:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   wire [1:0] mode = setup_q[SET_MODE_MSB:SET_MODE_LSB];
   wire hold = setup_q[SET_HOLD];
   wire cal_req = wr_go && rs_cur == REG_SETUP
                  && word_new[SET_MODE_MSB:SET_MODE_LSB] != MODE_NORMAL;
   wire [1:0] mode_next = cal_req ? word_new[SET_MODE_MSB:SET_MODE_LSB] : mode;
   seq_t start_state;
   always_comb begin
      case (mode_next)
         MODE_NORMAL: start_state = SQ_CONV;
         MODE_SELF, MODE_ZERO: start_state = SQ_ZERO;
         default: start_state = SQ_FULL;
      endcase
   end
   wire ext_stopped = crystal_attached && clock_q[CLK_OUTDIS];
   wire ext_tick = clock_input_pin_rise && (!clock_q[CLK_HALVE] || half_q);
   wire tick = !ext_stopped && (clock_q[CLK_INTOSC] || ext_tick);
   wire [2:0] rate_sel = {clock_q[CLK_FRANGE], clock_q[CLK_FS_MSB:0]};
   wire period_done = tick && period_q == DECIM[rate_sel] - 9'd1;
   wire step_done = period_done && !cal_req && !hold;
   wire result_new = step_done && seq_q == SQ_CONV;
   wire zero_done = step_done && seq_q == SQ_ZERO;
   wire full_done = step_done && seq_q == SQ_FULL;
   wire cal_finish = full_done || (zero_done && mode != MODE_SELF);
   wire [23:0] capture = {analog_sample, 8'h00};
   wire [15:0] corrected = analog_sample - offset_q[pair][23:8];
   wire [15:0] zero_code = setup_q[SET_UNIPOLAR] ? ZERO_UNIPOLAR : ZERO_BIPOLAR;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         seq_q <= SQ_HOLD;
         period_q <= 9'd0;
         half_q <= 1'b0;
      end else begin
         if (clock_input_pin_rise) half_q <= ~half_q;
         if (hold) begin
            seq_q <= SQ_HOLD;
            period_q <= 9'd0;
         end else if (seq_q == SQ_HOLD || cal_req) begin
            seq_q <= start_state;
            period_q <= 9'd0;
         end else if (period_done) begin
            period_q <= 9'd0;
            if (cal_finish) seq_q <= SQ_CONV;
            else if (zero_done) seq_q <= SQ_FULL;
         end else if (tick) begin
            period_q <= period_q + 9'd1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         setup_q <= SETUP_RESET;
         clock_q <= CLOCK_RESET_LOW;
         test_q <= TEST_RESET;
         result_q <= ZERO_UNIPOLAR;
         ready_n_q <= 1'b1;
         pd_q <= 1'b0;
         for (int k = 0; k < 3; k++) begin
            offset_q[k] <= OFFSET_RESET;
            gain_q[k] <= GAIN_RESET;
         end
      end else begin
         if (cmd_done) pd_q <= cmd_new[CMD_PD];
         if (wr_go && rs_cur == REG_SETUP) setup_q <= word_new[7:0];
         else if (cal_finish) setup_q[SET_MODE_MSB:SET_MODE_LSB] <= MODE_NORMAL;
         if (wr_go && rs_cur == REG_CLOCK) clock_q <= word_new[5:0];
         if (wr_go && rs_cur == REG_TEST) test_q <= word_new[7:0];
         if (wr_go && rs_cur == REG_OFFSET) offset_q[pair] <= word_new;
         else if (zero_done) offset_q[pair] <= capture;
         if (wr_go && rs_cur == REG_GAIN) gain_q[pair] <= word_new;
         else if (full_done) gain_q[pair] <= capture;
         if (result_new) result_q <= corrected + zero_code;
         if (result_new) ready_n_q <= 1'b0;
         else if (cal_req || rd_result_done) ready_n_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog and clock control outputs
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         input_short_q <= 1'b0;
         input_ref_q <= 1'b0;
         amp_gain_q <= 8'h01;
         osc_on_q <= 1'b0;
         osc_fast_q <= 1'b1;
         clock_output_pin_q <= 1'b0;
         buf_q <= 1'b0;
      end else begin
         input_short_q <= seq_q == SQ_ZERO && mode == MODE_SELF;
         input_ref_q <= seq_q == SQ_FULL && mode == MODE_SELF;
         amp_gain_q <= 8'h01 << setup_q[SET_GAIN_MSB:SET_GAIN_LSB];
         osc_on_q <= clock_q[CLK_INTOSC];
         osc_fast_q <= clock_q[CLK_FRANGE];
         clock_output_pin_q <= !clock_q[CLK_OUTDIS] && pin_q[3];
         buf_q <= setup_q[SET_BUF];
      end
   end

   assign link.sdo = sdo_q;
   assign link.result_ready_n = ready_n_q;
   assign input_short = input_short_q;
   assign input_ref_level = input_ref_q;
   assign amp_gain = amp_gain_q;
   assign internal_osc_on = osc_on_q;
   assign osc_fast = osc_fast_q;
   assign clock_output_pin = clock_output_pin_q;
   assign power_down = pd_q;
   assign buffer_on = buf_q;
endmodule : adc_device_end

// ### design/adc_host_end.sv
// Purpose: Host end: software registers over AXI4-Lite, serial master
// Assumes: One command byte plus its data per transfer
// Notes: Test register writes are refused
`timescale 1ns/100ps
module adc_host_end import adc_cal_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Link
   adc_link_if.host_end link
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001, H_LOW = 4'b0010, H_HIGH = 4'b0100, H_END = 4'b1000
   } host_state_t;

   host_state_t st_q;
   logic awready_q, bvalid_q, arready_q, rvalid_q, busy_q, refused_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q, shift_q;
   logic [23:0] tx_data_q, rx_q, rx_data_q;
   logic [4:0] len_q;
   logic [5:0] left_q;
   logic [7:0] div_q;
   logic sclk_q, cs_n_q, sdi_q;
   logic [1:0] s1_q, s2_q, s3_q, in_q;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers {ready_n, sdo}
   wire [1:0] in_raw = {link.result_ready_n, link.sdo};
   for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge resetn) begin
         if (!resetn) begin
            s1_q[i] <= 1'b1;
            s2_q[i] <= 1'b1;
            s3_q[i] <= 1'b1;
            in_q[i] <= 1'b1;
         end else begin
            s1_q[i] <= in_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) in_q[i] <= s3_q[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire wr_ok = awvalid && wvalid && !awready_q && !bvalid_q;
   wire rd_ok = arvalid && !arready_q && !rvalid_q;
   wire wr_tx = wr_ok && awaddr == HOST_TXDATA;
   wire wr_cmd = wr_ok && awaddr == HOST_COMMAND;
   wire wr_mapped = wr_tx || wr_cmd;
   wire [2:0] rs_w = wdata[CMD_RS_MSB:CMD_RS_LSB];
   wire test_write = rs_w == REG_TEST && !wdata[CMD_RW];
   wire go = wr_cmd && wstrb[0] && !busy_q && !test_write;
   wire [4:0] len_w = data_bits(rs_w);
   wire [23:0] tx_aligned = tx_data_q << (5'd24 - len_w);
   wire [31:0] status_rd = {29'h00000000, refused_q, in_q[1], busy_q};
   wire rd_mapped = araddr == HOST_TXDATA || araddr == HOST_COMMAND
                    || araddr == HOST_STATUS || araddr == HOST_RXDATA;
   wire [31:0] rd_word =
      (araddr == HOST_TXDATA) ? {8'h00, tx_data_q} :
      (araddr == HOST_STATUS) ? status_rd :
      (araddr == HOST_RXDATA) ? {8'h00, rx_data_q} : 32'h00000000;
   wire half_done = div_q == 8'(SCLK_HALF_CYCLES - 1);
   wire [23:0] rx_next = {rx_q[22:0], in_q[0]};
   wire [23:0] rx_mask = ~(24'hFFFFFF << len_q);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         awready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h00000000;
         tx_data_q <= 24'h000000;
         refused_q <= 1'b0;
      end else begin
         awready_q <= wr_ok;
         arready_q <= rd_ok;
         if (wr_ok) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_ok) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
         if (wr_tx) tx_data_q <= wdata[23:0];
         if (wr_cmd && wstrb[0]) refused_q <= busy_q || test_write;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial master, command byte first
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= H_IDLE;
         busy_q <= 1'b0;
         sclk_q <= 1'b1;
         cs_n_q <= 1'b1;
         sdi_q <= 1'b0;
         div_q <= 8'h00;
         shift_q <= 32'h00000000;
         left_q <= 6'h00;
         len_q <= 5'h00;
         rx_q <= 24'h000000;
         rx_data_q <= 24'h000000;
      end else begin
         div_q <= (st_q == H_IDLE || half_done) ? 8'h00 : div_q + 8'h01;
         case (st_q)
            H_IDLE: begin
               if (go) begin
                  busy_q <= 1'b1;
                  cs_n_q <= 1'b0;
                  sclk_q <= 1'b0;
                  sdi_q <= wdata[CMD_RS_MSB + 1] & 1'b0;
                  shift_q <= {wdata[6:0], tx_aligned, 1'b0};
                  len_q <= len_w;
                  left_q <= {1'b0, CMD_BITS} + {1'b0, len_w};
                  st_q <= H_LOW;
               end
            end
            H_LOW: begin
               if (half_done) begin
                  sclk_q <= 1'b1;
                  rx_q <= rx_next;
                  left_q <= left_q - 6'h01;
                  st_q <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (half_done) begin
                  if (left_q == 6'h00) begin
                     st_q <= H_END;
                  end else begin
                     sclk_q <= 1'b0;
                     sdi_q <= shift_q[31];
                     shift_q <= {shift_q[30:0], 1'b0};
                     st_q <= H_LOW;
                  end
               end
            end
            H_END: begin
               if (half_done) begin
                  cs_n_q <= 1'b1;
                  busy_q <= 1'b0;
                  rx_data_q <= rx_q & rx_mask;
                  st_q <= H_IDLE;
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   assign awready = awready_q;
   assign wready = awready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;
   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign link.sdi = sdi_q;
endmodule : adc_host_end

// ### verification/adc_link_props.sv
// Purpose: Wire checks on the serial link
// Assumes: Inputs are the adc_link_if signals
// Notes: One clock domain
`timescale 1ns/100ps
module adc_link_props (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic result_ready_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   chk_idle_clock: assert property (cs_n |-> sclk)
      else $error("serial clock low outside a frame");
   chk_frame_start: assert property ($fell(cs_n) |-> !sclk && !sdi)
      else $error("frame did not open with clock low and start bit");
   chk_low_half: assert property ($fell(sclk) |-> !sclk [*8])
      else $error("serial clock low half too short");
   chk_high_half: assert property ($rose(sclk) && !cs_n |-> sclk [*8])
      else $error("serial clock high half too short");
   chk_sdi_hold: assert property (!cs_n && sclk |-> $stable(sdi))
      else $error("host data moved while clock high");
   chk_sdo_settled: assert property ($rose(sclk) && !cs_n |-> sdo == $past(sdo, 3))
      else $error("device data not settled at rising edge");
   chk_sdo_hold: assert property ($rose(sclk) && !cs_n |=> $stable(sdo) [*2])
      else $error("device data moved right after rising edge");
   chk_frame_end: assert property ($rose(cs_n) |-> sclk && $past(sclk, 8))
      else $error("frame closed mid bit");
endmodule : adc_link_props

// ### verification/tb_top.sv
// Purpose: Host end and device end joined, driven over AXI4-Lite
// Assumes: Internal oscillator paces conversions
// Notes: Random values from a fixed seed
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top import adc_cal_pkg::*;;
   logic core_clk = 1'h0;
   logic resetn = 1'h0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awready, wready, bvalid, arready, rvalid, clk_out;
   logic [1:0] bresp, rresp;
   logic [15:0] sample = 16'h0;
   logic [7:0] amp_gain;
   logic [23:0] co [0:5];
   logic [2:0] cin = 3'h0;
   logic xtal = 1'h0;
   logic osc_on, osc_fast, in_short, in_ref;
   int n_short = 0, n_ref = 0;
   int seed = 99876;
   int n_mismatch = 0;
   int check_count = 0;
   adc_link_if link ();
   adc_host_end i_adc_host_end (.core_clk, .resetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .link(link.host_end));
   adc_device_end i_adc_device_end (.core_clk, .resetn, .link(link.device_end),
      .analog_sample(sample), .clock_input_pin(cin[2]), .crystal_attached(xtal),
      .input_short(in_short), .input_ref_level(in_ref), .amp_gain, .internal_osc_on(osc_on),
      .osc_fast,
      .clock_output_pin(clk_out), .power_down(), .buffer_on());
   adc_link_props i_adc_link_props (.core_clk, .resetn, .sclk(link.sclk), .cs_n(link.cs_n),
      .sdi(link.sdi), .sdo(link.sdo), .result_ready_n(link.result_ready_n));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] clk_exp(input logic [7:0] w);
      return {MAKER_ID_VALUE, 1'h0, w[5:0]};
   endfunction : clk_exp
   function automatic logic [15:0] res_exp(input logic [15:0] s, input logic u);
      return s - s + (u ? ZERO_UNIPOLAR : ZERO_BIPOLAR);
   endfunction : res_exp
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do @(posedge core_clk); while (awready !== 1'h1);
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      while (bvalid !== 1'h1) @(posedge core_clk);
      bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge core_clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      while (rvalid !== 1'h1) @(posedge core_clk);
      v = rdata;
      rready <= 1'h0;
   endtask : rd
   task automatic xfer(input logic [2:0] rs, input logic rw, input logic [1:0] ch,
      input logic [23:0] tx, output logic [31:0] rx);
      wr(HOST_TXDATA, {8'h00, tx});
      wr(HOST_COMMAND, {24'h0, 1'h0, rs, rw, 1'h0, ch});
      do rd(HOST_STATUS, rx); while (rx[0] !== 1'h0);
      rd(HOST_RXDATA, rx);
   endtask : xfer
   task automatic cal(input logic [7:0] su);
      xfer(REG_SETUP, 1'h0, 2'h1, {16'h0, su}, d);
      rd(HOST_STATUS, d);
      `CHK(d[1], 1'h1)
      do rd(HOST_STATUS, d); while (d[1] !== 1'h0);
      xfer(REG_SETUP, 1'h1, 2'h1, 24'h0, d);
      `CHK(d[7:6], MODE_NORMAL)
      xfer(REG_OFFSET, 1'h1, 2'h1, 24'h0, d);
   endtask : cal
   task automatic close_out;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #(CORE_PERIOD_NS / 2) core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cin <= cin + 3'h1;
      n_short <= n_short + in_short;
      n_ref <= n_ref + in_ref;
   end
   initial begin
      #(80000 * CORE_PERIOD_NS);
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      resetn <= 1'h1;
      xfer(REG_CLOCK, 1'h1, 2'h0, 24'h0, d);
      `CHK(d[7:0], clk_exp({2'h0, CLOCK_RESET_LOW}))
      `CHK(({osc_on, osc_fast}), 2'h1)
      d = 32'h0;
      repeat (8) @(posedge core_clk) d[0] |= clk_out;
      `CHK(d[0], 1'h1)
      xfer(REG_CLOCK, 1'h0, 2'h0, 24'hFF, d);
      xfer(REG_CLOCK, 1'h1, 2'h0, 24'h0, d);
      `CHK(d[7:0], clk_exp(8'hFF))
      `CHK(({osc_on, osc_fast}), 2'h3)
      `CHK(clk_out, 1'h0)
      for (int g = 0; g < 8; g++) begin
         xfer(REG_SETUP, 1'h0, 2'h0, 24'(g << 3 | 1), d);
         `CHK(amp_gain, 8'(1 << g))
      end
      for (int i = 0; i < 6; i++) begin
         xfer(3'(REG_OFFSET + i / 3), 1'h1, 2'(i % 3 == 2 ? 3 : i % 3), 24'h0, d);
         `CHK(d[23:0], i < 3 ? OFFSET_RESET : GAIN_RESET)
         co[i] = 24'($random(seed));
         xfer(3'(REG_OFFSET + i / 3), 1'h0, 2'(i % 3 == 2 ? 3 : i % 3), co[i], d);
         xfer(3'(REG_OFFSET + i / 3), 1'h1, 2'(i % 3 == 2 ? 3 : i % 3), 24'h0, d);
         `CHK(d[23:0], co[i])
      end
      xfer(REG_TEST, 1'h0, 2'h0, 24'h5A, d);
      rd(HOST_STATUS, d);
      `CHK(d[2], 1'h1)
      `CHK(d[1], 1'h1)
      sample <= 16'($random(seed));
      cal(8'h84);
      `CHK(d[23:0], {sample, 8'h00})
      xfer(REG_GAIN, 1'h1, 2'h1, 24'h0, d);
      `CHK(d[23:0], co[4])
      xfer(REG_RESULT, 1'h1, 2'h1, 24'h0, d);
      `CHK(d[15:0], res_exp(sample, 1'h1))
      co[1] = {sample, 8'h00};
      sample <= 16'($random(seed));
      cal(8'hC4);
      `CHK(d[23:0], co[1])
      xfer(REG_GAIN, 1'h1, 2'h1, 24'h0, d);
      `CHK(d[23:0], {sample, 8'h00})
      sample <= 16'($random(seed));
      cal(8'h40);
      `CHK(d[23:0], {sample, 8'h00})
      xfer(REG_GAIN, 1'h1, 2'h1, 24'h0, d);
      `CHK(d[23:0], {sample, 8'h00})
      `CHK(n_short, DECIM[7])
      `CHK(n_ref, DECIM[7])
      xtal <= 1'h1;
      xfer(REG_RESULT, 1'h1, 2'h1, 24'h0, d);
      `CHK(d[15:0], res_exp(sample, 1'h0))
      repeat (100) @(posedge core_clk);
      rd(HOST_STATUS, d);
      `CHK(d[1], 1'h1)
      close_out();
   end
endmodule : tb_top
